// ### src/plt_pkg.sv
// Constants, carrier types and helpers for the PHY link timer block
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`default_nettype none
package plt_pkg;

   // ---------------------------------------------------------------
   // Basic widths and clocking
   // ---------------------------------------------------------------
   localparam int CNT_W = 28;            // Holds 500 ms at 250 MHz
   localparam int MCLK_MHZ = 250;
   localparam int SYNC_STAGES = 2;
   localparam int PAGE_W = 16;

   // ---------------------------------------------------------------
   // Times as specified, each in its own unit
   // ---------------------------------------------------------------
   localparam int HB_DELAY_NS = 1200;
   localparam int HB_DUR_NS = 1000;
   localparam int JAB_ON_MS = 85;
   localparam int JAB_OFF_MS = 500;
   localparam int LP_WIDTH_NS = 100;
   localparam int NLP_PERIOD_MS = 16;
   localparam int FLP_CLK_US = 125;
   localparam int FLP_DATA_US = 62;
   localparam int FLP_BURST_MS = 2;
   localparam int FLP_PERIOD_MS = 16;
   localparam int SD_ON_MS = 1;
   localparam int SD_OFF_US = 350;
   localparam int LB_DEAD_US = 550;
   localparam int LB100_NS = 240;
   localparam int LB10_US = 2;
   localparam int ISO_CLR_US = 100;
   localparam int ISO_RST_US = 500;
   localparam real CS_OFF_US = 1.0;
   localparam int REF_CLK_NS = 20;
   localparam int BIT_100_NS = 10;
   localparam real TX_LAT_BITS = 17;
   localparam real CRS_ON_BITS = 18.5;
   localparam real CRS_OFF_BITS = 27;
   localparam real RX_LAT_BITS = 38;    // Elasticity buffer at its default 01

   // ---------------------------------------------------------------
   // Cycle counts on mclk
   // ---------------------------------------------------------------
   localparam logic [CNT_W-1:0] HB_DELAY_CYC = CNT_W'(HB_DELAY_NS * MCLK_MHZ / 1000);
   localparam logic [CNT_W-1:0] HB_DUR_CYC = CNT_W'(HB_DUR_NS * MCLK_MHZ / 1000);
   localparam logic [CNT_W-1:0] JAB_ON_CYC = CNT_W'(JAB_ON_MS * MCLK_MHZ * 1000);
   localparam logic [CNT_W-1:0] JAB_OFF_CYC = CNT_W'(JAB_OFF_MS * MCLK_MHZ * 1000);
   localparam logic [CNT_W-1:0] LP_WIDTH_CYC = CNT_W'(LP_WIDTH_NS * MCLK_MHZ / 1000);
   localparam logic [CNT_W-1:0] NLP_PERIOD_CYC = CNT_W'(NLP_PERIOD_MS * MCLK_MHZ * 1000);
   localparam logic [CNT_W-1:0] FLP_SLOT_CYC = CNT_W'(FLP_CLK_US * MCLK_MHZ);
   localparam logic [CNT_W-1:0] FLP_DATA_CYC = CNT_W'(FLP_DATA_US * MCLK_MHZ);
   localparam logic [CNT_W-1:0] FLP_PERIOD_CYC = CNT_W'(FLP_PERIOD_MS * MCLK_MHZ * 1000);
   localparam int FLP_SLOTS = FLP_BURST_MS * 1000 / FLP_CLK_US;
   localparam int SLOT_W = $clog2(FLP_SLOTS);
   localparam logic [CNT_W-1:0] SD_ON_CYC = CNT_W'(SD_ON_MS * MCLK_MHZ * 1000);
   localparam logic [CNT_W-1:0] SD_OFF_CYC = CNT_W'(SD_OFF_US * MCLK_MHZ);
   localparam logic [CNT_W-1:0] LB_DEAD_CYC = CNT_W'(LB_DEAD_US * MCLK_MHZ);
   localparam logic [CNT_W-1:0] LB100_CYC = CNT_W'(LB100_NS * MCLK_MHZ / 1000);
   localparam logic [CNT_W-1:0] LB10_CYC = CNT_W'(LB10_US * MCLK_MHZ);
   localparam logic [CNT_W-1:0] ISO_CLR_CYC = CNT_W'(ISO_CLR_US * MCLK_MHZ);
   localparam logic [CNT_W-1:0] ISO_RST_CYC = CNT_W'(ISO_RST_US * MCLK_MHZ);
   localparam logic [CNT_W-1:0] CS_OFF_CYC = CNT_W'(int'($floor(CS_OFF_US * MCLK_MHZ)));
   localparam logic [CNT_W-1:0] SYNC_LAT_CYC = CNT_W'(SYNC_STAGES);
   // Link capture flop plus synchroniser, charged against maximum delays
   localparam logic [CNT_W-1:0] XING_LAT_CYC = CNT_W'(SYNC_STAGES + (REF_CLK_NS * MCLK_MHZ + 999) / 1000);

   // ---------------------------------------------------------------
   // Reference clock pipeline depths, rounded up to whole cycles
   // ---------------------------------------------------------------
   localparam int TX_DLY_CYC = int'($ceil(TX_LAT_BITS * BIT_100_NS / REF_CLK_NS));
   localparam int CRS_ON_CYC = int'($ceil(CRS_ON_BITS * BIT_100_NS / REF_CLK_NS));
   localparam int CRS_OFF_CYC = int'($ceil(CRS_OFF_BITS * BIT_100_NS / REF_CLK_NS));
   localparam int RX_DLY_CYC = int'($ceil(RX_LAT_BITS * BIT_100_NS / REF_CLK_NS));

   // ---------------------------------------------------------------
   // Carrier types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic speed_100;
      logic loopback;
      logic autoneg_en;
   } plt_cfg_s;

   typedef struct packed {
      logic en;
      logic [1:0] d;
   } plt_tx_beat_s;

   typedef struct packed {
      logic carrier;
      logic valid;
      logic err;
      logic [1:0] d;
   } plt_line_rx_s;

   typedef struct packed {
      logic rx_dv;
      logic rx_er;
      logic [1:0] rxd;
   } plt_rmii_rx_s;

   typedef struct packed {
      logic tx_act;
      logic energy;
      logic rx10_act;
      logic iso_req;
      logic sw_rst;
   } plt_async_s;

   typedef struct packed {
      logic jabber;
      logic isolated;
   } plt_flag_s;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Decrement that parks at zero
   function automatic logic [CNT_W-1:0] plt_dec(input logic [CNT_W-1:0] c);
      return (c == '0) ? c : c - 1'b1;
   endfunction : plt_dec

   // Count threshold with known input latency removed, never below zero
   function automatic logic [CNT_W-1:0] plt_lim(input logic [CNT_W-1:0] l, input logic [CNT_W-1:0] lat);
      return (l > lat + 1'b1) ? l - lat - 1'b1 : '0;
   endfunction : plt_lim

endpackage : plt_pkg
`default_nettype wire

// ### src/plt_timers.sv
// PHY link timers: 10 Mb/s timers, link pulses, signal detect, loopback, isolate and RMII sequencing
`timescale 1ns/1ps
`default_nettype none
module plt_timers #(
   parameter logic [plt_pkg::CNT_W-1:0] JABBER_ON = plt_pkg::JAB_ON_CYC,      // Jabber entry, cycles
   parameter logic [plt_pkg::CNT_W-1:0] JABBER_OFF = plt_pkg::JAB_OFF_CYC,    // Jabber hold, cycles
   parameter logic [plt_pkg::CNT_W-1:0] NLP_PERIOD = plt_pkg::NLP_PERIOD_CYC, // Link pulse period
   parameter logic [plt_pkg::CNT_W-1:0] FLP_SLOT = plt_pkg::FLP_SLOT_CYC,     // Clock pulse spacing
   parameter logic [plt_pkg::CNT_W-1:0] FLP_DATA = plt_pkg::FLP_DATA_CYC,     // Data pulse offset
   parameter logic [plt_pkg::CNT_W-1:0] FLP_PERIOD = plt_pkg::FLP_PERIOD_CYC, // Burst period
   parameter logic [plt_pkg::CNT_W-1:0] SD_ON = plt_pkg::SD_ON_CYC,           // Signal detect on
   parameter logic [plt_pkg::CNT_W-1:0] SD_OFF = plt_pkg::SD_OFF_CYC,         // Signal detect off
   parameter logic [plt_pkg::CNT_W-1:0] LB_DEAD = plt_pkg::LB_DEAD_CYC,       // Loopback dead-time
   parameter logic [plt_pkg::CNT_W-1:0] ISO_CLR = plt_pkg::ISO_CLR_CYC,       // Isolate exit after clear
   parameter logic [plt_pkg::CNT_W-1:0] ISO_RST = plt_pkg::ISO_RST_CYC        // Isolate exit after reset
) (
   input wire logic mclk,                                   // Core clock, 250 MHz
   input wire logic reset_n,                                // Async reset, active low
   input wire logic reference_clock_in,                     // Reference clock, link domain
   input wire plt_pkg::plt_cfg_s mode_pins,                 // Speed, loopback, autoneg straps
   input wire logic isolate_ctrl,                           // Control register isolate bit 10
   input wire logic soft_reset,                             // Software reset level
   input wire logic line_energy,                            // 100 Mb/s compliant signal seen
   input wire logic line_rx_10_active,                      // 10BASE-T receive activity
   input wire logic [plt_pkg::PAGE_W-1:0] flp_page,         // Link code word, quasi-static
   input wire plt_pkg::plt_tx_beat_s rmii_tx,               // MAC transmit, reference domain
   input wire plt_pkg::plt_line_rx_s line_rx,               // Line receive, reference domain
   output var plt_pkg::plt_tx_beat_s line_tx,               // Symbols toward line
   output var plt_pkg::plt_rmii_rx_s rmii_rx,               // Receive dibit, error, valid
   output logic crs_dv,                                     // Carrier sense / data valid
   output logic derived_clock_output,                       // Clock out from reference
   output logic collision_heartbeat,                        // Heartbeat after transmit
   output logic jabber,                                     // Jabber state
   output logic link_pulse,                                 // Normal or fast link pulse
   output logic signal_detect,                              // Qualified 100 Mb/s signal
   output logic loop_rx_dv,                                 // Loopback receive valid
   output logic carrier_sense,                              // 10BASE-T carrier sense
   output logic isolated                                    // Isolate state
);
   import plt_pkg::*;

   // ---------------------------------------------------------------
   // State of the core clock domain
   // ---------------------------------------------------------------
   typedef struct packed {
      plt_cfg_s cfg_m1;
      plt_cfg_s cfg_m2;
      plt_async_s in_m1;
      plt_async_s in_m2;
      logic [PAGE_W-1:0] page_m1;
      logic [PAGE_W-1:0] page_m2;
      logic tx_prev;
      logic lb_prev;
      logic [CNT_W-1:0] hb_cnt;
      logic heartbeat;
      logic [CNT_W-1:0] jab_cnt;
      logic jabber;
      logic [CNT_W-1:0] per_cnt;
      logic [CNT_W-1:0] slot_cnt;
      logic [SLOT_W-1:0] slot_idx;
      logic in_burst;
      logic [CNT_W-1:0] wid_cnt;
      logic pulse;
      logic [CNT_W-1:0] sd_cnt;
      logic sd;
      logic [CNT_W-1:0] lb_dead;
      logic [CNT_W-1:0] lb_cnt;
      logic lb_dv;
      logic [CNT_W-1:0] cs_cnt;
      logic cs;
      logic [CNT_W-1:0] iso_cnt;
      logic isolated;
   } plt_core_s;

   // ---------------------------------------------------------------
   // State of the reference clock domain
   // ---------------------------------------------------------------
   typedef struct packed {
      plt_flag_s flag_l1;
      plt_flag_s flag_l2;
      plt_tx_beat_s [TX_DLY_CYC-1:0] tx_pipe;
      plt_line_rx_s [RX_DLY_CYC-1:0] rx_pipe;
      plt_tx_beat_s line_tx;
      plt_rmii_rx_s rmii_rx;
      logic tgl;
   } plt_link_s;

   plt_core_s core;
   plt_core_s next_core;
   plt_link_s link;
   plt_link_s next_link;
   logic pulse_on;
   logic [CNT_W-1:0] pulse_period;
   logic [CNT_W-1:0] lb_lim;
   logic crs_level;
   logic drain;

   // Pulses run for autoneg, or for an idle 10 Mb/s link without it
   assign pulse_on = core.cfg_m2.autoneg_en |
                     (!core.cfg_m2.speed_100 & !core.in_m2.tx_act & !core.in_m2.rx10_act);
   assign pulse_period = core.cfg_m2.autoneg_en ? FLP_PERIOD : NLP_PERIOD;
   assign lb_lim = core.cfg_m2.speed_100 ? LB100_CYC : LB10_CYC;

   // ---------------------------------------------------------------
   // Core domain next state
   // ---------------------------------------------------------------
   always_comb begin
      next_core = core;
      // Two-stage synchronisers; stage one feeds only stage two
      next_core.cfg_m1 = mode_pins;
      next_core.cfg_m2 = core.cfg_m1;
      next_core.in_m1.tx_act = link.tx_pipe[0].en;
      next_core.in_m1.energy = line_energy;
      next_core.in_m1.rx10_act = line_rx_10_active;
      next_core.in_m1.iso_req = isolate_ctrl;
      next_core.in_m1.sw_rst = soft_reset;
      next_core.in_m2 = core.in_m1;
      next_core.page_m1 = flp_page;
      next_core.page_m2 = core.page_m1;
      next_core.tx_prev = core.in_m2.tx_act;
      next_core.lb_prev = core.cfg_m2.loopback;

      // Heartbeat: one load on transmit end, window at the tail of the count
      if (!core.cfg_m2.speed_100 && core.tx_prev && !core.in_m2.tx_act) begin
         next_core.hb_cnt = HB_DELAY_CYC + HB_DUR_CYC;
      end else begin
         next_core.hb_cnt = plt_dec(core.hb_cnt);
      end
      next_core.heartbeat = (next_core.hb_cnt != '0) && (next_core.hb_cnt <= HB_DUR_CYC);

      // Jabber: watchdog on continuous 10 Mb/s transmit, then a fixed hold
      if (core.jabber) begin
         next_core.jab_cnt = plt_dec(core.jab_cnt);
         if (core.jab_cnt <= 1) begin
            next_core.jabber = 1'b0;
            next_core.jab_cnt = '0;
         end
      end else if (!core.cfg_m2.speed_100 && core.in_m2.tx_act) begin
         next_core.jab_cnt = core.jab_cnt + 1'b1;
         if (core.jab_cnt >= plt_lim(JABBER_ON, XING_LAT_CYC)) begin
            next_core.jabber = 1'b1;
            next_core.jab_cnt = JABBER_OFF;
         end
      end else begin
         next_core.jab_cnt = '0;
      end

      // Fast link pulse burst: clock pulse per slot, data pulse on ones
      next_core.wid_cnt = plt_dec(core.wid_cnt);
      if (core.in_burst) begin
         next_core.slot_cnt = core.slot_cnt + 1'b1;
         if (core.slot_cnt == '0) begin
            next_core.wid_cnt = LP_WIDTH_CYC;
         end
         if (core.slot_cnt == FLP_DATA && core.page_m2[core.slot_idx]) begin
            next_core.wid_cnt = LP_WIDTH_CYC;
         end
         if (core.slot_cnt >= FLP_SLOT - 1'b1) begin
            next_core.slot_cnt = '0;
            next_core.slot_idx = core.slot_idx + 1'b1;
            if (core.slot_idx == SLOT_W'(FLP_SLOTS - 1)) begin
               next_core.in_burst = 1'b0;
            end
         end
      end

      // Period timer shared by normal pulses and bursts
      if (!pulse_on) begin
         next_core.per_cnt = '0;
         next_core.in_burst = 1'b0;
      end else begin
         next_core.per_cnt = (core.per_cnt >= pulse_period - 1'b1) ? '0 : core.per_cnt + 1'b1;
         if (core.per_cnt == '0) begin
            if (core.cfg_m2.autoneg_en) begin
               next_core.in_burst = 1'b1;
               next_core.slot_cnt = '0;
               next_core.slot_idx = '0;
            end else if (core.wid_cnt == '0) begin // Never stretch a pulse already out
               next_core.wid_cnt = LP_WIDTH_CYC;
            end
         end
      end
      if (!core.cfg_m2.autoneg_en) begin
         next_core.in_burst = 1'b0;
      end
      next_core.pulse = (next_core.wid_cnt != '0);

      // Signal detect: input must hold its new level for the whole qualify time
      if (core.in_m2.energy != core.sd) begin
         next_core.sd_cnt = core.sd_cnt + 1'b1;
         if (core.sd_cnt >= plt_lim(core.sd ? SD_OFF : SD_ON, SYNC_LAT_CYC)) begin
            next_core.sd = core.in_m2.energy;
            next_core.sd_cnt = '0;
         end
      end else begin
         next_core.sd_cnt = '0;
      end

      // Loopback: dead-time on 100 Mb/s entry, then bounded enable-to-valid delay
      if (!core.cfg_m2.loopback) begin
         next_core.lb_dead = '0;
         next_core.lb_cnt = '0;
         next_core.lb_dv = 1'b0;
      end else if (!core.lb_prev) begin
         next_core.lb_dead = core.cfg_m2.speed_100 ? LB_DEAD : '0;
         next_core.lb_dv = 1'b0;
      end else if (core.lb_dead != '0) begin
         next_core.lb_dead = plt_dec(core.lb_dead);
         next_core.lb_dv = 1'b0;
      end else if (!core.in_m2.tx_act) begin
         next_core.lb_cnt = '0;
         next_core.lb_dv = 1'b0;
      end else if (core.lb_cnt >= plt_lim(lb_lim, XING_LAT_CYC)) begin
         next_core.lb_dv = 1'b1;
      end else begin
         next_core.lb_cnt = core.lb_cnt + 1'b1;
      end

      // 10BASE-T carrier sense hangs on briefly after activity ends
      if (!core.cfg_m2.speed_100 && core.in_m2.rx10_act) begin
         next_core.cs = 1'b1;
         next_core.cs_cnt = '0;
      end else if (core.cs) begin
         next_core.cs_cnt = core.cs_cnt + 1'b1;
         if (core.cs_cnt >= plt_lim(CS_OFF_CYC, SYNC_LAT_CYC)) begin
            next_core.cs = 1'b0;
            next_core.cs_cnt = '0;
         end
      end else begin
         next_core.cs_cnt = '0;
      end

      // Isolate: software reset outranks the isolate control bit
      if (core.in_m2.sw_rst) begin
         next_core.isolated = 1'b1;
         next_core.iso_cnt = ISO_RST;
      end else if (core.in_m2.iso_req) begin
         next_core.isolated = 1'b1;
         next_core.iso_cnt = ISO_CLR;
      end else if (core.isolated) begin
         next_core.iso_cnt = plt_dec(core.iso_cnt);
         if (core.iso_cnt <= SYNC_LAT_CYC + 1'b1) begin
            next_core.isolated = 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Core domain registers
   // ---------------------------------------------------------------
   // Leaves reset isolated, with the reset exit timer already loaded
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         core <= '0;
         core.isolated <= 1'b1;
         core.iso_cnt <= ISO_RST;
      end else begin
         core <= next_core;
      end
   end

   // ---------------------------------------------------------------
   // Reference domain next state
   // ---------------------------------------------------------------
   // Carrier window from two taps: rise at the on tap, fall at the off tap
   assign crs_level = link.rx_pipe[CRS_ON_CYC].carrier | link.rx_pipe[CRS_OFF_CYC].carrier;
   // Data still in flight after carrier has dropped
   assign drain = !crs_level & link.rx_pipe[RX_DLY_CYC-1].valid;

   always_comb begin
      next_link = link;
      next_link.flag_l1.jabber = core.jabber;
      next_link.flag_l1.isolated = core.isolated;
      next_link.flag_l2 = link.flag_l1;
      // Transmit beat captured on the rising edge, delayed to the line
      next_link.tx_pipe = {link.tx_pipe[TX_DLY_CYC-2:0], rmii_tx};
      next_link.line_tx = link.tx_pipe[TX_DLY_CYC-1];
      if (link.flag_l2.jabber) begin
         next_link.line_tx = '0;
      end
      // Receive path: fixed latency through the elasticity pipeline
      next_link.rx_pipe = {link.rx_pipe[RX_DLY_CYC-2:0], line_rx};
      next_link.rmii_rx.rx_dv = link.rx_pipe[RX_DLY_CYC-1].valid;
      next_link.rmii_rx.rx_er = link.rx_pipe[RX_DLY_CYC-1].err;
      next_link.rmii_rx.rxd = link.rx_pipe[RX_DLY_CYC-1].d;
      if (link.flag_l2.isolated) begin
         next_link.rmii_rx = '0;
      end
      // Toggle phase during drain; first drain cycle reads low
      next_link.tgl = drain ? !link.tgl : 1'b0;
   end

   // ---------------------------------------------------------------
   // Reference domain registers
   // ---------------------------------------------------------------
   always_ff @(posedge reference_clock_in or negedge reset_n) begin
      if (!reset_n) begin
         link <= '0;
         link.flag_l1.isolated <= 1'b1;
         link.flag_l2.isolated <= 1'b1;
      end else begin
         link <= next_link;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Carrier-valid has no output register so it leaves with the tap, not a cycle later
   assign crs_dv = !link.flag_l2.isolated & (crs_level | (drain & link.tgl));
   // The output is the reference itself, so its phases track the input in either mode
   assign derived_clock_output = reference_clock_in;
   assign line_tx = link.line_tx;
   assign rmii_rx = link.rmii_rx;
   assign collision_heartbeat = core.heartbeat;
   assign jabber = core.jabber;
   assign link_pulse = core.pulse;
   assign signal_detect = core.sd;
   assign loop_rx_dv = core.lb_dv;
   assign carrier_sense = core.cs;
   assign isolated = core.isolated;

endmodule : plt_timers
`default_nettype wire

// ### test/plt_mac_model.sv
// MAC-side transmit model on the reference clock
`timescale 1ns/1ps
`default_nettype none
module plt_mac_model (
   input wire logic ref_clk, // Reference clock
   input wire logic send, // Frame request level
   output var plt_pkg::plt_tx_beat_s tx // Transmit beat
);
   import plt_pkg::*;
   // Launch after the edge, so the capturing edge sees settled beats; idle dibit is 00
   always @(posedge ref_clk) begin
      tx <= #1 '{en: send, d: send ? tx.d + 2'h1 : 2'h0};
   end
   initial tx = '0;
endmodule : plt_mac_model
`default_nettype wire

// ### test/plt_timers_chk.sv
// Port assertions for the link timer block
`timescale 1ns/1ps
`default_nettype none
module plt_timers_chk (
   input wire logic mclk, // Core clock
   input wire logic reset_n, // Async reset
   input wire logic reference_clock_in, // Link clock
   input wire logic isolate_ctrl, // Isolate request
   input wire logic line_energy, // Line signal
   input wire logic line_rx_10_active, // 10M receive
   input wire plt_pkg::plt_tx_beat_s line_tx, // To line
   input wire logic derived_clock_output, // Clock out
   input wire logic collision_heartbeat, // Heartbeat
   input wire logic jabber, // Jabber
   input wire logic link_pulse, // Link pulse
   input wire logic signal_detect, // Signal detect
   input wire logic carrier_sense, // Carrier sense
   input wire logic isolated // Isolate state
);
   import plt_pkg::*;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   // -------------------------------
   // Checks, all in the mclk domain
   // -------------------------------
   hb_window_a: assert property (
      $rose(collision_heartbeat) |-> ##249 collision_heartbeat ##1 !collision_heartbeat)
      else $error("heartbeat window wrong");
   jab_line_a: assert property ($rose(jabber) |-> ##20 !line_tx.en)
      else $error("line still driven in jabber");
   jab_hold_a: assert property ($rose(jabber) |-> ##300 jabber)
      else $error("jabber released early");
   pulse_width_a: assert property ($rose(link_pulse) |-> ##24 link_pulse ##1 !link_pulse)
      else $error("link pulse width wrong");
   sd_cause_a: assert property ($rose(signal_detect) |-> $past(line_energy, 200))
      else $error("signal detect without energy");
   iso_enter_a: assert property (isolate_ctrl [*5] |-> isolated)
      else $error("isolate not entered");
   dclk_follow_a: assert property (derived_clock_output == reference_clock_in)
      else $error("derived clock differs");
   cs_drop_a: assert property ($fell(line_rx_10_active) |-> ##[1:252] !carrier_sense)
      else $error("carrier sense held too long");
   // Main scenarios reached
   hb_seen_c: cover property ($rose(collision_heartbeat));
   jab_seen_c: cover property ($rose(jabber));
   sd_seen_c: cover property ($rose(signal_detect));
endmodule : plt_timers_chk
bind plt_timers plt_timers_chk plt_timers_chk_i (.mclk, .reset_n, .reference_clock_in, .isolate_ctrl,
   .line_energy, .line_rx_10_active, .line_tx, .derived_clock_output, .collision_heartbeat, .jabber,
   .link_pulse, .signal_detect, .carrier_sense, .isolated);
`default_nettype wire

// ### test/plt_timers_tb_top.sv
// Self-checking bench for the link timer block
`timescale 1ns/1ps
`default_nettype none
module plt_timers_tb_top;
   import plt_pkg::*;
   logic mclk, ref_clk, reset_n, iso, srst, energy, rx10, send, hb, jab, sd, cs, isold, crs, dclk, lp, lbdv;
   logic [15:0] page;
   plt_line_rx_s lrx;
   plt_rmii_rx_s rrx;
   plt_cfg_s mode;
   plt_tx_beat_s tx, ltx;
   int bad_count, comparisons, cyc;
   // -------------------------------
   // Clocks, unrelated in phase
   // -------------------------------
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   initial begin
      ref_clk = 1'b0;
      #3;
      forever #7.5 ref_clk = ~ref_clk;
   end
   // Short counts keep the run brief; waits below follow them
   plt_timers #(.JABBER_ON(28'h190), .JABBER_OFF(28'h258), .NLP_PERIOD(28'h7D0), .FLP_SLOT(28'hC8),
      .FLP_DATA(28'h64), .FLP_PERIOD(28'hFA0), .SD_ON(28'h12C), .SD_OFF(28'h96), .LB_DEAD(28'hC8),
      .ISO_CLR(28'h64), .ISO_RST(28'h12C)) plt_timers_i (.mclk, .reset_n, .reference_clock_in(ref_clk),
      .mode_pins(mode), .isolate_ctrl(iso), .soft_reset(srst), .line_energy(energy), .line_rx_10_active(rx10),
      .flp_page(page), .rmii_tx(tx), .line_rx(lrx), .line_tx(ltx), .rmii_rx(rrx), .crs_dv(crs),
      .derived_clock_output(dclk), .collision_heartbeat(hb), .jabber(jab), .link_pulse(lp), .signal_detect(sd),
      .loop_rx_dv(lbdv), .carrier_sense(cs), .isolated(isold));
   plt_mac_model plt_mac_model_i (.ref_clk, .send, .tx);
   // Compare, count, report
   task automatic chk(input logic [27:0] seen, input logic [27:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // Inputs move 1 ns after an mclk edge, except the line beats in t_rx, which move 1 ns after a ref_clk edge
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick
   task automatic results;
      $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : results
   // Cut a hang short; the tests need about 4100 cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 8000) begin
         bad_count++;
         results();
      end
   end
   // -------------------------------
   // Scenarios
   // -------------------------------
   task automatic t_iso_reset;
      chk(isold, 1'b1);
      tick(310);
      chk(isold, 1'b0);
      $display("iso_reset done");
   endtask : t_iso_reset
   task automatic t_frame;
      send = 1'b1;
      tick(20);
      chk(ltx.en, 1'b0);
      tick(40);
      chk(ltx.en, 1'b1);
      send = 1'b0;
      tick(250);
      chk(hb, 1'b0);
      tick(150);
      chk(hb, 1'b1);
      tick(220);
      chk(hb, 1'b0);
      $display("frame done");
   endtask : t_frame
   task automatic t_jabber;
      send = 1'b1;
      tick(420);
      chk(jab, 1'b1);
      tick(30);
      chk(ltx.en, 1'b0);
      send = 1'b0;
      tick(500);
      chk(jab, 1'b1);
      tick(150);
      chk(jab, 1'b0);
      $display("jabber done");
   endtask : t_jabber
   task automatic t_detect;
      mode = 3'h4;
      energy = 1'b1;
      tick(250);
      chk(sd, 1'b0);
      tick(60);
      chk(sd, 1'b1);
      energy = 1'b0;
      tick(160);
      chk(sd, 1'b0);
      mode = 3'h0;
      $display("detect done");
   endtask : t_detect
   task automatic t_iso_clear;
      iso = 1'b1;
      tick(5);
      chk(isold, 1'b1);
      iso = 1'b0;
      tick(90);
      chk(isold, 1'b1);
      tick(15);
      chk(isold, 1'b0);
      srst = 1'b1;
      tick(5);
      chk(isold, 1'b1);
      srst = 1'b0;
      tick(290);
      chk(isold, 1'b1);
      tick(15);
      chk(isold, 1'b0);
      $display("iso_clear done");
   endtask : t_iso_clear
   task automatic t_carrier;
      rx10 = 1'b1;
      tick(4);
      chk(cs, 1'b1);
      rx10 = 1'b0;
      tick(240);
      chk(cs, 1'b1);
      tick(15);
      chk(cs, 1'b0);
      $display("carrier done");
   endtask : t_carrier
   // Dead-time hides valid at first, then valid follows the enable
   task automatic t_loop;
      mode = 3'h6;
      send = 1'b1;
      tick(150);
      chk(lbdv, 1'b0);
      tick(150);
      chk(lbdv, 1'b1);
      send = 1'b0;
      tick(20);
      chk(lbdv, 1'b0);
      mode = 3'h0;
      $display("loop done");
   endtask : t_loop
   // Pulses held off first so the burst starts from a known point
   task automatic t_flp;
      mode = 3'h4;
      page = 16'h0001;
      tick(30);
      mode = 3'h1;
      tick(10);
      chk(lp, 1'b1);
      tick(100);
      chk(lp, 1'b1);
      tick(200);
      chk(lp, 1'b0);
      mode = 3'h0;
      $display("flp done");
   endtask : t_flp
   // Line beats move on the link clock
   task automatic t_rx;
      @(posedge ref_clk) #1 lrx = 5'h1A;
      repeat (12) @(posedge ref_clk);
      #1 chk(crs, 1'b1);
      chk(dclk, ref_clk);
      repeat (9) @(posedge ref_clk);
      #1 chk(rrx, 4'hA);
      lrx = 5'h00;
      repeat (30) @(posedge ref_clk);
      #1 chk(crs, 1'b0);
      chk(rrx, 4'h0);
      $display("rx done");
   endtask : t_rx
   initial begin
      {reset_n, iso, srst, energy, rx10, send} = 6'h00;
      page = 16'h0000;
      lrx = 5'h00;
      mode = 3'h0;
      tick(5);
      reset_n = 1'b1;
      t_iso_reset();
      t_frame();
      t_jabber();
      t_detect();
      t_iso_clear();
      t_loop();
      t_flp();
      t_carrier();
      t_rx();
      results();
   end
endmodule : plt_timers_tb_top
`default_nettype wire
